/* include/uart_timer_pkg.sv */
// Package: register map, field positions, reset values and state types of the timer-baud serial port
`default_nettype none
package uart_timer_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] BUF_OFS    = 8'h04;
  localparam logic [7:0] TMR_OFS    = 8'h08;
  localparam logic [7:0] TLOW_OFS   = 8'h0c;
  // Control register bit positions
  localparam int MODE_BIT  = 7;
  localparam int ONE_BIT   = 6;
  localparam int MCE_BIT   = 5;
  localparam int REN_BIT   = 4;
  localparam int TB8_BIT   = 3;
  localparam int RB8_BIT   = 2;
  localparam int TI_BIT    = 1;
  localparam int RI_BIT    = 0;
  // Timer register field positions
  localparam int RELOAD_LSB = 0;
  localparam int TEN_BIT    = 8;
  localparam int CKSEL_LSB  = 9;
  localparam int IEN_BIT    = 12;
  // Timer clock source codes
  localparam logic [2:0] CKSEL_DIV1  = 3'h0;
  localparam logic [2:0] CKSEL_DIV4  = 3'h1;
  localparam logic [2:0] CKSEL_DIV12 = 3'h2;
  localparam logic [2:0] CKSEL_DIV48 = 3'h3;
  localparam logic [2:0] CKSEL_EXT8  = 3'h4;
  // Prescaler and frame counts
  localparam logic [5:0] PRE_LAST    = 6'h2f;
  localparam logic [2:0] EXT_LAST    = 3'h7;
  localparam logic [3:0] DATA_LAST   = 4'h7;
  localparam logic [7:0] TMR_TOP     = 8'hff;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_LOAD  = 6'h02,
    TX_START = 6'h04,
    TX_DATA  = 6'h08,
    TX_NINTH = 6'h10,
    TX_STOP  = 6'h20
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_NINTH = 5'h08,
    RX_STOP  = 5'h10
  } rx_state_t;

  // Software-visible control bits
  typedef struct packed {
    logic frame_mode_select;
    logic multiproc_check_enable;
    logic receive_enable_bit;
    logic ninth_transmit_bit;
    logic ninth_receive_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } ctrl_t;

  // Baud timer setup and live counters
  typedef struct packed {
    logic [7:0] baud_timer_reload_byte;
    logic       run;
    logic [2:0] cksel;
    logic       irq_enable;
    logic [7:0] baud_timer_low_byte;
    logic [7:0] rx_copy;
    logic       tx_half;
    logic       rx_half;
    logic [5:0] pre;
    logic [2:0] ext_cnt;
  } timer_t;

  typedef struct packed {
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    ctrl_t       ctrl;
    timer_t      tmr;
    tx_state_t   tx_st;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_cnt;
    logic        tx_pin;
    rx_state_t   rx_st;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic        rx_prev;
    logic        rx_nine;
    logic [7:0]  rbuf;
    logic        irq;
  } state_t;
endpackage : uart_timer_pkg
`default_nettype wire

/* hdl/uart_timer_baud.sv */
// Design: serial port with timer-derived baud clock, reached over AHB-Lite
// Function
// - Full duplex; a mode bit picks 8-bit or 9-bit data frames.
// - One buffer address: writes feed transmitter, reads return receive buffer.
// - Receive shifter is separate from buffer, so second byte can arrive.
// - With interrupt enabled, request is high while either done flag is set.
// - Done flags stay set until software writes them clear.
// - Transmit bit clock comes from baud timer low byte overflows, auto-reloaded.
// - Receive bit clock uses a hidden timer copy sharing the reload byte.
// - A start edge forces an immediate reload of the receive timer copy.
// - Both overflow streams are halved; baud = clock/(256-reload)/2.
// - Timer clock: system clock /1, /4, /12, /48 or external oscillator /8.
// - 8-bit frame: low start, eight data bits LSB first, stop bit.
// - 8-bit mode stores data in buffer and stop level in ninth receive bit.
// - Writing the buffer starts transmission of that byte; a write while busy is dropped.
// - Transmit-done flag sets when the stop bit period begins.
// - Reception starts only while the receive enable bit is one.
// - Byte accepted only if receive-done is clear; in 8-bit mode check bit needs stop one.
// - Accept loads buffer, ninth bit, receive-done; otherwise all three unchanged.
// - On overrun the buffer keeps the first byte; later bits are lost.
// - Mode bit zero selects 8-bit, one selects 9-bit variable baud.
// - 9-bit frame adds programmable ninth bit; received ninth goes to flag.
// - 9-bit mode with check bit accepts only bytes whose ninth bit is one.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`default_nettype none
module uart_timer_baud
  import uart_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Timer clock source, serial pins and interrupt request
  input  wire logic        ext_osc_tick,
  input  wire logic        receive_pin,
  output logic             transmit_pin,
  output logic             irq
);

  state_t s_q;
  state_t s_d;

  logic       addr_ok;
  logic       tmr_tick;
  logic       tx_ovf;
  logic       rx_ovf;
  logic       tx_bit;
  logic       rx_smp;
  logic       start_seen;
  logic       ninth_val;
  logic       accept;
  logic       wr_ctrl;
  logic       wr_buf;
  logic [7:0] ctrl_rd;

  assign addr_ok    = hsel && htrans[1] && hready;
  assign wr_ctrl    = s_q.wr_pend && (s_q.wr_addr == CTRL_OFS);
  assign wr_buf     = s_q.wr_pend && (s_q.wr_addr == BUF_OFS);
  assign tx_ovf     = s_q.tmr.run && tmr_tick && (s_q.tmr.baud_timer_low_byte == TMR_TOP);
  assign rx_ovf     = s_q.tmr.run && tmr_tick && (s_q.tmr.rx_copy == TMR_TOP);
  assign tx_bit     = tx_ovf && s_q.tmr.tx_half;
  assign rx_smp     = rx_ovf && !s_q.tmr.rx_half;
  assign start_seen = (s_q.rx_st == RX_IDLE) && s_q.ctrl.receive_enable_bit && s_q.tmr.run &&
                      s_q.rx_prev && !receive_pin;
  // Stop level stands in for the ninth bit in 8-bit mode
  assign ninth_val  = s_q.ctrl.frame_mode_select ? s_q.rx_nine : receive_pin;
  assign accept     = (s_q.rx_st == RX_STOP) && rx_smp && !s_q.ctrl.receive_done_flag &&
                      (!s_q.ctrl.multiproc_check_enable || ninth_val);
  assign ctrl_rd    = {s_q.ctrl.frame_mode_select, 1'b1, s_q.ctrl.multiproc_check_enable,
                       s_q.ctrl.receive_enable_bit, s_q.ctrl.ninth_transmit_bit,
                       s_q.ctrl.ninth_receive_bit, s_q.ctrl.transmit_done_flag,
                       s_q.ctrl.receive_done_flag};

  // Timer clock source select
  always_comb begin
    case (s_q.tmr.cksel)
      CKSEL_DIV1:  tmr_tick = 1'b1;
      CKSEL_DIV4:  tmr_tick = (s_q.tmr.pre[1:0] == 2'h3);
      CKSEL_DIV12: tmr_tick = (s_q.tmr.pre == 6'h0b) || (s_q.tmr.pre == 6'h17) ||
                              (s_q.tmr.pre == 6'h23) || (s_q.tmr.pre == PRE_LAST);
      CKSEL_DIV48: tmr_tick = (s_q.tmr.pre == PRE_LAST);
      CKSEL_EXT8:  tmr_tick = ext_osc_tick && (s_q.tmr.ext_cnt == EXT_LAST);
      default:     tmr_tick = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rx_prev = receive_pin;
    s_d.irq = s_q.tmr.irq_enable &&
              (s_q.ctrl.transmit_done_flag || s_q.ctrl.receive_done_flag);

    // Bus: read data is fetched in the address phase so the data phase needs no wait
    s_d.hready  = 1'b1;
    s_d.hresp   = 1'b0;
    s_d.wr_pend = 1'b0;
    if (addr_ok) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr[7:0];
      s_d.hrdata  = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          CTRL_OFS: s_d.hrdata = {24'h00_0000, ctrl_rd};
          BUF_OFS:  s_d.hrdata = {24'h00_0000, s_q.rbuf};
          TMR_OFS:  s_d.hrdata = {19'h0_0000, s_q.tmr.irq_enable, s_q.tmr.cksel,
                                  s_q.tmr.run, s_q.tmr.baud_timer_reload_byte};
          TLOW_OFS: s_d.hrdata = {24'h00_0000, s_q.tmr.baud_timer_low_byte};
          default:  s_d.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // Prescaler and external oscillator divider
    s_d.tmr.pre = (s_q.tmr.pre == PRE_LAST) ? 6'h00 : s_q.tmr.pre + 6'h01;
    if (ext_osc_tick) begin
      s_d.tmr.ext_cnt = s_q.tmr.ext_cnt + 3'h1;
    end

    // Transmit timer, receive timer copy and their halving stages
    if (s_q.tmr.run && tmr_tick) begin
      s_d.tmr.baud_timer_low_byte = tx_ovf ? s_q.tmr.baud_timer_reload_byte
                                           : s_q.tmr.baud_timer_low_byte + 8'h01;
      s_d.tmr.rx_copy = rx_ovf ? s_q.tmr.baud_timer_reload_byte
                               : s_q.tmr.rx_copy + 8'h01;
    end
    if (tx_ovf) begin
      s_d.tmr.tx_half = !s_q.tmr.tx_half;
    end
    if (rx_ovf) begin
      s_d.tmr.rx_half = !s_q.tmr.rx_half;
    end
    // First receive overflow then lands half a bit in: the start bit centre
    if (start_seen) begin
      s_d.tmr.rx_copy = s_q.tmr.baud_timer_reload_byte;
      s_d.tmr.rx_half = 1'b0;
    end

    // Software writes in the data phase
    if (wr_ctrl) begin
      s_d.ctrl.frame_mode_select      = hwdata[MODE_BIT];
      s_d.ctrl.multiproc_check_enable = hwdata[MCE_BIT];
      s_d.ctrl.receive_enable_bit     = hwdata[REN_BIT];
      s_d.ctrl.ninth_transmit_bit     = hwdata[TB8_BIT];
      s_d.ctrl.ninth_receive_bit      = hwdata[RB8_BIT];
      s_d.ctrl.transmit_done_flag     = hwdata[TI_BIT];
      s_d.ctrl.receive_done_flag      = hwdata[RI_BIT];
    end
    if (s_q.wr_pend && (s_q.wr_addr == TMR_OFS)) begin
      s_d.tmr.baud_timer_reload_byte = hwdata[RELOAD_LSB +: 8];
      s_d.tmr.run        = hwdata[TEN_BIT];
      s_d.tmr.cksel      = hwdata[CKSEL_LSB +: 3];
      s_d.tmr.irq_enable = hwdata[IEN_BIT];
    end
    if (s_q.wr_pend && (s_q.wr_addr == TLOW_OFS)) begin
      s_d.tmr.baud_timer_low_byte = hwdata[7:0];
    end

    // Transmitter; a write while busy is dropped so the frame on the pin stays whole
    if (wr_buf && (s_q.tx_st == TX_IDLE)) begin
      s_d.tx_sh = hwdata[7:0];
      s_d.tx_st = TX_LOAD;
    end else if (tx_bit) begin
      case (s_q.tx_st)
        TX_LOAD: begin
          s_d.tx_pin = 1'b0;
          s_d.tx_st  = TX_START;
        end
        TX_START: begin
          s_d.tx_pin = s_q.tx_sh[0];
          s_d.tx_sh  = {1'b0, s_q.tx_sh[7:1]};
          s_d.tx_cnt = 4'h0;
          s_d.tx_st  = TX_DATA;
        end
        TX_DATA: begin
          if (s_q.tx_cnt == DATA_LAST) begin
            if (s_q.ctrl.frame_mode_select) begin
              s_d.tx_pin = s_q.ctrl.ninth_transmit_bit;
              s_d.tx_st  = TX_NINTH;
            end else begin
              s_d.tx_pin = 1'b1;
              s_d.ctrl.transmit_done_flag = 1'b1;
              s_d.tx_st  = TX_STOP;
            end
          end else begin
            s_d.tx_pin = s_q.tx_sh[0];
            s_d.tx_sh  = {1'b0, s_q.tx_sh[7:1]};
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
          end
        end
        TX_NINTH: begin
          s_d.tx_pin = 1'b1;
          s_d.ctrl.transmit_done_flag = 1'b1;
          s_d.tx_st  = TX_STOP;
        end
        TX_STOP: s_d.tx_st = TX_IDLE;
        TX_IDLE: s_d.tx_st = TX_IDLE;
        default: begin
          s_d.tx_pin = 1'b1;
          s_d.tx_st  = TX_IDLE;
        end
      endcase
    end

    // Receiver shifts independently of the buffer, which only changes on accept
    if (start_seen) begin
      s_d.rx_st = RX_START;
    end else if (rx_smp) begin
      case (s_q.rx_st)
        RX_START: begin
          s_d.rx_cnt = 4'h0;
          s_d.rx_st  = receive_pin ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          s_d.rx_sh  = {receive_pin, s_q.rx_sh[7:1]};
          s_d.rx_cnt = s_q.rx_cnt + 4'h1;
          if (s_q.rx_cnt == DATA_LAST) begin
            s_d.rx_st = s_q.ctrl.frame_mode_select ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH: begin
          s_d.rx_nine = receive_pin;
          s_d.rx_st   = RX_STOP;
        end
        RX_STOP: s_d.rx_st = RX_IDLE;
        RX_IDLE: s_d.rx_st = RX_IDLE;
        default: s_d.rx_st = RX_IDLE;
      endcase
    end
    // Rejected or overrun bytes leave buffer, ninth bit and flag alone
    if (accept) begin
      s_d.rbuf = s_q.rx_sh;
      s_d.ctrl.ninth_receive_bit = ninth_val;
      s_d.ctrl.receive_done_flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q        <= '0;
      s_q.hready <= 1'b1;
      s_q.tx_st  <= TX_IDLE;
      s_q.tx_pin <= 1'b1;
      s_q.rx_st  <= RX_IDLE;
      s_q.rx_prev <= 1'b1;
      s_q.rbuf   <= RESET_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout    = s_q.hready;
  assign hrdata       = s_q.hrdata;
  assign hresp        = s_q.hresp;
  assign transmit_pin = s_q.tx_pin;
  assign irq          = s_q.irq;

  property p_ti_at_stop;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.tx_st != TX_STOP) ##1 (s_q.tx_st == TX_STOP) |-> s_q.ctrl.transmit_done_flag;
  endproperty
  a_ti_at_stop: assert property (p_ti_at_stop) else $error("stop began without tx done");

  property p_start_low;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.tx_st == TX_START) |-> !s_q.tx_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_reject_keeps;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.rx_st == RX_STOP && rx_smp && s_q.ctrl.receive_done_flag && !wr_ctrl)
      |=> $stable(s_q.rbuf) && s_q.ctrl.receive_done_flag;
  endproperty
  a_reject_keeps: assert property (p_reject_keeps) else $error("overrun changed buffer");

  property p_ren_gate;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.rx_st == RX_IDLE && !s_q.ctrl.receive_enable_bit) |=> (s_q.rx_st == RX_IDLE);
  endproperty
  a_ren_gate: assert property (p_ren_gate) else $error("receive began while disabled");

  property p_flag_sticky;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ctrl.receive_done_flag && !wr_ctrl) |=> s_q.ctrl.receive_done_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("rx done cleared by hardware");

  property p_irq_follows;
    @(posedge hclk) disable iff (!hresetn)
    ##1 irq == $past(s_q.tmr.irq_enable &&
                     (s_q.ctrl.transmit_done_flag || s_q.ctrl.receive_done_flag));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt request mismatch");

  property p_rx_reload;
    @(posedge hclk) disable iff (!hresetn)
    start_seen |=> (s_q.tmr.rx_copy == $past(s_q.tmr.baud_timer_reload_byte)) &&
                   (s_q.rx_st == RX_START);
  endproperty
  a_rx_reload: assert property (p_rx_reload) else $error("start did not reload rx timer");

  property p_write_starts;
    @(posedge hclk) disable iff (!hresetn)
    (wr_buf && s_q.tx_st == TX_IDLE) |=> (s_q.tx_st == TX_LOAD) && s_q.tx_pin;
  endproperty
  a_write_starts: assert property (p_write_starts) else $error("buffer write did not start tx");

  property p_halved;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.tx_st == TX_LOAD && tx_ovf && !s_q.tmr.tx_half && !wr_buf) |=> (s_q.tx_st == TX_LOAD);
  endproperty
  a_halved: assert property (p_halved) else $error("bit advanced on odd overflow");

  property p_mce_nine;
    @(posedge hclk) disable iff (!hresetn)
    (accept && s_q.ctrl.multiproc_check_enable) |=> s_q.ctrl.ninth_receive_bit;
  endproperty
  a_mce_nine: assert property (p_mce_nine) else $error("accepted byte with ninth bit low");

  property p_stop_high;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.tx_st == TX_STOP) |-> s_q.tx_pin;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  property p_ninth_tx;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.tx_st == TX_DATA && tx_bit && s_q.tx_cnt == DATA_LAST && s_q.ctrl.frame_mode_select)
      |=> (s_q.tx_pin == $past(s_q.ctrl.ninth_transmit_bit));
  endproperty
  a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit not from setting");

  property p_accept_loads;
    @(posedge hclk) disable iff (!hresetn)
    accept |=> s_q.ctrl.receive_done_flag && (s_q.rbuf == $past(s_q.rx_sh));
  endproperty
  a_accept_loads: assert property (p_accept_loads) else $error("accept did not load");

  property p_stop_to_ninth;
    @(posedge hclk) disable iff (!hresetn)
    (accept && !s_q.ctrl.frame_mode_select)
      |=> (s_q.ctrl.ninth_receive_bit == $past(receive_pin));
  endproperty
  a_stop_to_ninth: assert property (p_stop_to_ninth) else $error("stop level not kept");

  property p_false_start;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.rx_st == RX_START && rx_smp && receive_pin) |=> (s_q.rx_st == RX_IDLE);
  endproperty
  a_false_start: assert property (p_false_start) else $error("high start not dropped");

  property p_tx_reload;
    @(posedge hclk) disable iff (!hresetn)
    (tx_ovf && !(s_q.wr_pend && s_q.wr_addr == TLOW_OFS))
      |=> (s_q.tmr.baud_timer_low_byte == $past(s_q.tmr.baud_timer_reload_byte));
  endproperty
  a_tx_reload: assert property (p_tx_reload) else $error("timer did not reload");

  property p_rx_copy_count;
    @(posedge hclk) disable iff (!hresetn)
    (s_q.tmr.run && tmr_tick && !rx_ovf && !start_seen)
      |=> (s_q.tmr.rx_copy == $past(s_q.tmr.rx_copy) + 8'h01);
  endproperty
  a_rx_copy_count: assert property (p_rx_copy_count) else $error("rx timer did not count");

endmodule : uart_timer_baud
`default_nettype wire

/* test/uart_far_end.sv */
// Far-end serial model: sends frames on the receive line and decodes the transmit line
`default_nettype none
module uart_far_end (
  // Clock and serial lines
  input  wire logic hclk,
  input  wire logic transmit_pin,
  output var  logic receive_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_len = 4;
  logic       nine = 1'b0;
  logic [8:0] got = '0;
  logic       got_stop = 1'b0;
  // Line idles high, as a pulled-up wire would
  initial receive_pin = 1'b1;
  // Centre sampling: a design with a drifting bit clock shows up as wrong bits
  initial forever begin
    @(negedge transmit_pin);
    repeat (bit_len / 2) @(posedge hclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_len) @(posedge hclk);
      got[i] = transmit_pin;
    end
    repeat (bit_len) @(posedge hclk);
    got_stop = transmit_pin;
  end
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] fr;
    fr = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      receive_pin <= fr[i];
      repeat (bit_len) @(posedge hclk);
    end
    receive_pin <= 1'b1;
  endtask : send
endmodule : uart_far_end
`default_nettype wire

/* test/uart_timer_baud_tb.sv */
// Testbench: register, baud, transmit and receive checks of the timer-baud serial port
`default_nettype none
module uart_timer_baud_tb;
  import uart_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        ext_osc_tick, receive_pin, transmit_pin, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          num_errors, check_count, low, c;
  int          per[5] = '{4, 16, 48, 192, 64};
  uart_timer_baud uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_osc_tick(ext_osc_tick),
    .receive_pin(receive_pin), .transmit_pin(transmit_pin), .irq(irq));
  uart_far_end far (.hclk(hclk), .transmit_pin(transmit_pin), .receive_pin(receive_pin));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // External oscillator stand-in: one tick every second system clock
  always @(posedge hclk) ext_osc_tick <= (ext_osc_tick !== 1'b1);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Entered just after a rising edge; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, '0);
    check(name, rd, exp);
  endtask : rdc
  task automatic wait_flag(input int b);
    rd = '0;
    for (int i = 0; i < 3000 && rd[b] !== 1'b1; i++) bus(1'b0, CTRL_OFS, '0);
  endtask : wait_flag
  // Data LSB must be one so the start bit alone sets the low time
  task automatic tx(input logic [7:0] d, input int p);
    bus(1'b1, BUF_OFS, {24'h000000, d});
    low = 0;
    c = 0;
    for (int i = 0; i < 5000 && transmit_pin !== 1'b0; i++) @(posedge hclk);
    while (transmit_pin === 1'b0 && low < 5000) begin
      @(posedge hclk);
      low++;
    end
    while (irq !== 1'b1 && c < 5000) begin
      @(posedge hclk);
      c++;
    end
    wait_flag(TI_BIT);
    repeat (2 * p) @(posedge hclk);
  endtask : tx
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    num_errors = 0;
    check_count = 0;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("tx idle", transmit_pin, 1'b1);
    rdc(CTRL_OFS, 32'h40, "ctrl reset");
    check("okay resp", hresp, 1'b0);
    rdc(TMR_OFS, 32'h0, "timer reset");
    rdc(8'h10, 32'h0, "unmapped");
    bus(1'b1, TLOW_OFS, 32'h5a);
    rdc(TLOW_OFS, 32'h5a, "low byte");
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, TMR_OFS, 32'h11fe | (k << CKSEL_LSB));
      far.bit_len = per[k];
      tx(8'h01, per[k]);
      check("bit period", low, per[k]);
      check("done at stop", c, 8 * per[k] + 1);
      rdc(CTRL_OFS, 32'h42, "done held");
      check("irq set", irq, 1'b1);
      bus(1'b1, CTRL_OFS, '0);
      repeat (2) @(posedge hclk);
      check("irq clear", irq, 1'b0);
    end
    far.bit_len = 4;
    bus(1'b1, TMR_OFS, 32'h11fe);
    far.send(9'h03c, 1'b1);
    repeat (4) @(posedge hclk);
    rdc(CTRL_OFS, 32'h40, "rx disabled");
    bus(1'b1, CTRL_OFS, 32'h10);
    fork
      far.send(9'h03c, 1'b1);
      tx(8'ha5, 4);
    join
    check("far data", far.got[7:0], 8'ha5);
    check("far stop", far.got_stop, 1'b1);
    rdc(CTRL_OFS, 32'h57, "rx accept");
    rdc(BUF_OFS, 32'h3c, "rx data");
    fork
      far.send(9'h0c3, 1'b1);
      begin
        repeat (12) @(posedge hclk);
        bus(1'b1, CTRL_OFS, 32'h10);
      end
    join
    repeat (4) @(posedge hclk);
    rdc(BUF_OFS, 32'hc3, "second byte");
    far.send(9'h066, 1'b1);
    repeat (4) @(posedge hclk);
    rdc(BUF_OFS, 32'hc3, "overrun keep");
    bus(1'b1, CTRL_OFS, 32'h30);
    far.send(9'h05a, 1'b0);
    repeat (4) @(posedge hclk);
    rdc(CTRL_OFS, 32'h70, "bad stop");
    bus(1'b1, CTRL_OFS, 32'hb8);
    far.nine = 1'b1;
    far.send(9'h077, 1'b1);
    repeat (4) @(posedge hclk);
    rdc(CTRL_OFS, 32'hf8, "ninth zero");
    far.send(9'h199, 1'b1);
    repeat (4) @(posedge hclk);
    rdc(CTRL_OFS, 32'hfd, "ninth one");
    rdc(BUF_OFS, 32'h99, "nine data");
    // Receive-done would hold the request high and hide the transmit-done edge
    bus(1'b1, CTRL_OFS, 32'hb8);
    tx(8'h81, 4);
    check("done at ninth", c, 9 * 4 + 1);
    check("far nine", far.got, 9'h181);
    check("far stop9", far.got_stop, 1'b1);
    test_done();
  end
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule : uart_timer_baud_tb
`default_nettype wire
